// ---- rtc_pkg.sv ----
// Shared constants, types and helpers for the modulo real-time counter
package rtc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;   // Register address width
  localparam int DATA_W = 32;  // Register data width
  localparam int CNT_W  = 16;  // Counter width

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;  // Source, clock select, clear
  localparam logic [ADDR_W-1:0] OFS_MOD    = 8'h04;  // Modulo value
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;  // Live count, read only
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;  // Sticky events, read clears
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h10;  // Interrupt enables
  localparam logic [ADDR_W-1:0] OFS_ADC    = 8'h14;  // Converter start control

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SRC_LSB   = 0;  // rtc_source_select, two bits
  localparam int CTRL_ACLK_BIT  = 2;  // rtc_aclk_select
  localparam int CTRL_CLEAR_BIT = 3;  // Write one to zero the counter
  localparam int ADC_SEL_LSB    = 0;  // adc_trigger_select, two bits
  localparam int ADC_SOFT_BIT   = 2;  // adc_soft_start, self clearing
  localparam int STAT_OVF_BIT   = 0;  // Overflow event flag
  localparam int EVT_W          = 1;  // Number of event bits

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] MOD_RESET  = 16'hFFFF;  // Full 16-bit period
  localparam logic [1:0]       SRC_RESET  = 2'h0;      // Reserved: halted
  localparam logic             ACLK_RESET = 1'h0;      // Sub-main clock
  localparam logic [1:0]       ADC_RESET  = 2'h0;      // Software start
  localparam logic [EVT_W-1:0] MASK_RESET = 1'h0;      // All masked

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_RESERVED = 2'h0,  // No clock, counter holds
    SRC_SUB_AUX  = 2'h1,  // sub_main_clock or auxiliary_clock
    SRC_CRYSTAL  = 2'h2,  // crystal_clock
    SRC_VLO      = 2'h3   // very_low_osc_clock
  } src_type;

  typedef enum logic [1:0] {
    ADC_TRIG_SOFT  = 2'h0,  // adc_soft_start bit
    ADC_TRIG_RTC   = 2'h1,  // Counter overflow event
    ADC_TRIG_TIMER = 2'h2,  // timer1_ccr1_out_b
    ADC_TRIG_RSVD  = 2'h3   // Reserved, never starts
  } adc_trig_type;

  typedef enum logic [1:0] {
    ACTIVE_MODE,
    LOW_POWER_MODE_0,
    LOW_POWER_MODE_3,
    DEEP_STANDBY_MODE
  } power_mode_type;

  // Raw clock pins, each from its own oscillator domain
  typedef struct packed {
    logic aux;       // auxiliary_clock
    logic sub_main;  // sub_main_clock
    logic crystal;   // crystal_clock
    logic vlo;       // very_low_osc_clock
  } clk_pins_type;

  // Clock selection carried to the tick generator
  typedef struct packed {
    src_type src;       // rtc_source_select
    logic    aclk_sel;  // rtc_aclk_select
  } cfg_type;

  // Modes in which an overflow must wake the processor
  function automatic logic is_low_power(input power_mode_type m);
    is_low_power = (m != ACTIVE_MODE);
  endfunction

endpackage

// ---- rtc_clock_tick.sv ----
// Source clock synchroniser and selected-edge tick generator
`timescale 1ns/1ps
module rtc_clock_tick (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire rtc_pkg::clk_pins_type clk_pins,
  input  wire rtc_pkg::cfg_type      cfg,
  output logic                       tick_q
);

  // ----------------------------------------------------------------
  // Synchroniser chains
  // ----------------------------------------------------------------
  localparam int NSRC = 4;  // One chain per oscillator

  logic [NSRC-1:0] meta_q;  // First stage, read only by stage two
  logic [NSRC-1:0] sync_q;  // Second stage, safe to use
  logic [NSRC-1:0] hist_q;  // Previous safe level
  logic [NSRC-1:0] rise;    // Rising edge per source
  logic            tick_d;  // Next tick

  // Each pin gets its own two-stage chain and edge history
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          hist_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= clk_pins[gi];
          sync_q[gi] <= meta_q[gi];
          hist_q[gi] <= sync_q[gi];
        end
      end
      assign rise[gi] = sync_q[gi] & ~hist_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  // Selecting edges, not levels, so a source switch makes no false tick
  always_comb begin
    unique case (cfg.src)
      rtc_pkg::SRC_RESERVED: tick_d = 1'b0;
      rtc_pkg::SRC_SUB_AUX:  tick_d = cfg.aclk_sel ? rise[3] : rise[2];
      rtc_pkg::SRC_CRYSTAL:  tick_d = rise[1];
      rtc_pkg::SRC_VLO:      tick_d = rise[0];
    endcase
  end

  // Registered so the counter sees a clean one-cycle enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  reserved_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg.src == rtc_pkg::SRC_RESERVED |=> !tick_q)
    else $error("tick seen with reserved source");

endmodule // rtc_clock_tick

// ---- rtc_adc_trigger.sv ----
// Converter start-source multiplexer
`timescale 1ns/1ps
module rtc_adc_trigger (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire rtc_pkg::adc_trig_type trig_sel,
  input  wire logic                  soft_start,
  input  wire logic                  rtc_event,
  input  wire logic                  timer1_ccr1_out_b,
  output logic                       start_q
);

  // ----------------------------------------------------------------
  // Start selection
  // ----------------------------------------------------------------
  logic timer_hist_q;  // Last timer output level
  logic start_d;       // Next start pulse

  // Timer output is a level; only its rising edge starts a conversion
  always_comb begin
    unique case (trig_sel)
      rtc_pkg::ADC_TRIG_SOFT:  start_d = soft_start;
      rtc_pkg::ADC_TRIG_RTC:   start_d = rtc_event;
      rtc_pkg::ADC_TRIG_TIMER: start_d = timer1_ccr1_out_b & ~timer_hist_q;
      rtc_pkg::ADC_TRIG_RSVD:  start_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_hist_q <= 1'b0;
      start_q      <= 1'b0;
    end else begin
      timer_hist_q <= timer1_ccr1_out_b;
      start_q      <= start_d;
    end
  end

  soft_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trig_sel == rtc_pkg::ADC_TRIG_SOFT && soft_start |=> start_q)
    else $error("software start not passed on");

  reserved_sel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trig_sel == rtc_pkg::ADC_TRIG_RSVD |=> !start_q)
    else $error("start issued on reserved select");

endmodule // rtc_adc_trigger

// ---- rtc_modulo_counter.sv ----
// Modulo real-time counter with event routing, wake-up and registers
`timescale 1ns/1ps
module rtc_modulo_counter (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // Register port
  input  wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input  wire logic [rtc_pkg::DATA_W-1:0] wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [rtc_pkg::DATA_W-1:0]   rd_data,
  // Clock pins and system state
  input  wire rtc_pkg::clk_pins_type   clk_pins,
  input  wire rtc_pkg::power_mode_type power_mode,
  input  wire logic                    timer1_ccr1_out_b,
  // Event outputs
  output logic                         capture_input_1b,
  output logic                         adc_start,
  output logic                         cpu_wake,
  output logic                         irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = rtc_pkg::CNT_W;  // Counter width
  localparam int DW = rtc_pkg::DATA_W; // Bus width
  localparam int EW = rtc_pkg::EVT_W;  // Event count

  // Configuration registers
  rtc_pkg::cfg_type       cfg_q;       // Clock source selection
  rtc_pkg::cfg_type       cfg_d;
  logic [CW-1:0]          mod_q;       // Modulo value
  logic [CW-1:0]          mod_d;
  logic [EW-1:0]          mask_q;      // Interrupt enables
  logic [EW-1:0]          mask_d;
  rtc_pkg::adc_trig_type  adc_sel_q;   // Converter start source
  rtc_pkg::adc_trig_type  adc_sel_d;
  logic                   soft_q;      // Software start pulse
  logic                   soft_d;
  logic                   clear_q;     // Counter clear pulse
  logic                   clear_d;

  // Counter state
  logic [CW-1:0]          cnt_q;       // Live count
  logic [CW-1:0]          cnt_d;
  logic                   ovf_q;       // One-cycle overflow event
  logic                   ovf_d;
  logic                   tick;        // Selected clock edge enable

  // Event and interrupt state
  logic [EW-1:0]          stat_q;      // Sticky event flags
  logic [EW-1:0]          stat_d;
  logic                   irq_q;
  logic                   irq_d;
  logic                   wake_q;
  logic                   wake_d;
  logic                   capt_q;
  logic                   capt_d;

  // Bus read path
  logic [DW-1:0]          rdata_q;
  logic [DW-1:0]          rdata_d;

  // Write and read decode
  logic                   wr_ctrl;
  logic                   wr_mod;
  logic                   wr_mask;
  logic                   wr_adc;
  logic                   rd_stat;

  assign wr_ctrl = wr_en && addr == rtc_pkg::OFS_CTRL;
  assign wr_mod  = wr_en && addr == rtc_pkg::OFS_MOD;
  assign wr_mask = wr_en && addr == rtc_pkg::OFS_MASK;
  assign wr_adc  = wr_en && addr == rtc_pkg::OFS_ADC;
  assign rd_stat = rd_en && addr == rtc_pkg::OFS_STATUS;

  // ----------------------------------------------------------------
  // Clock source and tick
  // ----------------------------------------------------------------
  // Every oscillator is resynchronised; ref_clk must run well above the
  // fastest source, so a fast sub-main clock would be undersampled
  rtc_clock_tick u_tick (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .clk_pins (clk_pins),
    .cfg      (cfg_q),
    .tick_q   (tick)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software writes; pulse bits fall back to zero the next cycle
  always_comb begin
    cfg_d     = cfg_q;
    mod_d     = mod_q;
    mask_d    = mask_q;
    adc_sel_d = adc_sel_q;
    soft_d    = 1'b0;
    clear_d   = 1'b0;
    if (wr_ctrl) begin
      // Source and clock select, both under software control
      cfg_d.src      = rtc_pkg::src_type'(wr_data[rtc_pkg::CTRL_SRC_LSB +: 2]);
      cfg_d.aclk_sel = wr_data[rtc_pkg::CTRL_ACLK_BIT];
      clear_d        = wr_data[rtc_pkg::CTRL_CLEAR_BIT];
    end
    if (wr_mod) begin
      mod_d = wr_data[CW-1:0];
    end
    if (wr_mask) begin
      mask_d = wr_data[EW-1:0];
    end
    if (wr_adc) begin
      // Soft start only counts while the soft source is selected
      adc_sel_d = rtc_pkg::adc_trig_type'(wr_data[rtc_pkg::ADC_SEL_LSB +: 2]);
      soft_d    = wr_data[rtc_pkg::ADC_SOFT_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q.src      <= rtc_pkg::src_type'(rtc_pkg::SRC_RESET);
      cfg_q.aclk_sel <= rtc_pkg::ACLK_RESET;
      mod_q          <= rtc_pkg::MOD_RESET;
      mask_q         <= rtc_pkg::MASK_RESET;
      adc_sel_q      <= rtc_pkg::adc_trig_type'(rtc_pkg::ADC_RESET);
      soft_q         <= 1'b0;
      clear_q        <= 1'b0;
    end else begin
      cfg_q          <= cfg_d;
      mod_q          <= mod_d;
      mask_q         <= mask_d;
      adc_sel_q      <= adc_sel_d;
      soft_q         <= soft_d;
      clear_q        <= clear_d;
    end
  end

  // ----------------------------------------------------------------
  // Modulo counter
  // ----------------------------------------------------------------
  // Power mode does not gate the counter: only the source clock does.
  // A clear beats a coincident tick so software sees a clean zero.
  always_comb begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (clear_q) begin
      cnt_d = '0;
    end else if (tick) begin
      if (cnt_q >= mod_q) begin
        // Wrap; also catches a modulo lowered below the count
        cnt_d = '0;
        ovf_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  // ----------------------------------------------------------------
  // Event routing
  // ----------------------------------------------------------------
  // Timer capture and wake both follow the overflow by one cycle.
  // Sub-main as source is meant for active mode only; in standby the
  // clock usually stops, so no wake would ever come from it.
  always_comb begin
    capt_d = ovf_q;
    wake_d = ovf_q && rtc_pkg::is_low_power(power_mode);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capt_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      capt_q <= capt_d;
      wake_q <= wake_d;
    end
  end

  // Converter start selection lives in its own small block
  rtc_adc_trigger u_adc (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .trig_sel          (adc_sel_q),
    .soft_start        (soft_q),
    .rtc_event         (ovf_q),
    .timer1_ccr1_out_b (timer1_ccr1_out_b),
    .start_q           (adc_start)
  );

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  // Read clears the flags, but an event in the same cycle survives
  always_comb begin
    stat_d = rd_stat ? '0 : stat_q;
    stat_d[rtc_pkg::STAT_OVF_BIT] = stat_d[rtc_pkg::STAT_OVF_BIT] | ovf_q;
    irq_d  = |(stat_q & mask_q);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Data stands one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d = '0;
    if (rd_en) begin
      unique case (addr)
        rtc_pkg::OFS_CTRL: begin
          rdata_d[rtc_pkg::CTRL_SRC_LSB +: 2]  = cfg_q.src;
          rdata_d[rtc_pkg::CTRL_ACLK_BIT]      = cfg_q.aclk_sel;
        end
        rtc_pkg::OFS_MOD:    rdata_d[CW-1:0] = mod_q;
        rtc_pkg::OFS_COUNT:  rdata_d[CW-1:0] = cnt_q;
        rtc_pkg::OFS_STATUS: rdata_d[EW-1:0] = stat_q;
        rtc_pkg::OFS_MASK:   rdata_d[EW-1:0] = mask_q;
        rtc_pkg::OFS_ADC:    rdata_d[rtc_pkg::ADC_SEL_LSB +: 2] = adc_sel_q;
        default:             rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from their flip-flops
  assign rd_data          = rdata_q;
  assign capture_input_1b = capt_q;
  assign cpu_wake         = wake_q;
  assign irq              = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_wrap;
    tick && !clear_q && cnt_q >= mod_q;
  endsequence

  sequence s_ovf_route;
    ovf_q ##1 capt_q;
  endsequence

  counter_wrap_a: assert property (s_wrap |=> cnt_q == '0 && ovf_q)
    else $error("counter did not wrap at modulo");

  counter_step_a: assert property (
    tick && !clear_q && cnt_q < mod_q |=> cnt_q == $past(cnt_q) + 1'b1 && !ovf_q)
    else $error("counter did not step by one");

  runs_any_mode_a: assert property (
    tick && !clear_q && mod_q != '0 |=> cnt_q != $past(cnt_q))
    else $error("counter stalled despite clock tick");

  wake_low_power_a: assert property (
    s_wrap ##1 rtc_pkg::is_low_power(power_mode) |=> wake_q)
    else $error("no wake on overflow in low power");

  no_wake_active_a: assert property (
    power_mode == rtc_pkg::ACTIVE_MODE || !ovf_q |=> !wake_q)
    else $error("spurious wake");

  capture_route_a: assert property (s_wrap |=> s_ovf_route)
    else $error("overflow missed timer capture input");

  adc_on_event_a: assert property (
    ovf_q && adc_sel_q == rtc_pkg::ADC_TRIG_RTC |=> adc_start)
    else $error("overflow did not start conversion");

  adc_no_event_a: assert property (
    ovf_q && adc_sel_q != rtc_pkg::ADC_TRIG_RTC && adc_sel_q != rtc_pkg::ADC_TRIG_TIMER && !soft_q |=> !adc_start)
    else $error("overflow started conversion when not selected");

  flag_sticky_a: assert property (
    stat_q[rtc_pkg::STAT_OVF_BIT] && !rd_stat |=> stat_q[rtc_pkg::STAT_OVF_BIT])
    else $error("overflow flag dropped without read");

  flag_set_wins_a: assert property (ovf_q |=> stat_q[rtc_pkg::STAT_OVF_BIT])
    else $error("overflow flag not set");

  irq_follows_a: assert property (
    1'b1 |=> irq_q == |($past(stat_q) & $past(mask_q)))
    else $error("interrupt does not track flag and enable");

endmodule // rtc_modulo_counter

// ---- rtc_far_side.sv ----
// Partner model: oscillator pins, timer output and on-chip event consumers
`timescale 1ns/1ps
module rtc_far_side (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             capture_input_1b,
  input  wire logic             adc_start,
  output rtc_pkg::clk_pins_type clk_pins,
  output logic                  timer1_ccr1_out_b,
  output logic [15:0]           capture_count_q,
  output logic [15:0]           start_count_q
);
  // ----------------------------------------
  // Oscillators stand still between bursts
  // ----------------------------------------
  initial begin
    clk_pins = '0;
    timer1_ccr1_out_b = 1'b0;
  end

  // Eight-cycle period keeps every pin slower than a quarter of ref_clk
  task automatic edges(input int pin, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge ref_clk);
      clk_pins[pin] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clk_pins[pin] <= 1'b0;
    end
  endtask

  // One rising edge on the timer output
  task automatic timer_pulse();
    @(posedge ref_clk);
    timer1_ccr1_out_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    timer1_ccr1_out_b <= 1'b0;
  endtask

  // ----------------------------------------
  // Capture input and converter start counters
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_count_q <= 16'h0000;
      start_count_q   <= 16'h0000;
    end else begin
      capture_count_q <= capture_count_q + 16'(capture_input_1b);
      start_count_q   <= start_count_q + 16'(adc_start);
    end
  end
endmodule  // rtc_far_side

// ---- rtc_modulo_counter_tb_top.sv ----
// Self-checking testbench for the modulo real-time counter
`timescale 1ns/1ps
module rtc_modulo_counter_tb_top;
  logic [7:0]              addr;
  logic [31:0]             wr_data, rd_data, got;
  logic                    ref_clk, reset_n, wr_en, rd_en, timer1_ccr1_out_b;
  logic                    capture_input_1b, adc_start, cpu_wake, irq;
  rtc_pkg::clk_pins_type   clk_pins;
  rtc_pkg::power_mode_type power_mode;
  logic [15:0]             capture_count, start_count, wake_count_q, c0, s0, w0;
  int                      mismatches, samples_checked, cycles;
  // Reset table: six registers then one unmapped place
  logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rst [7] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  // Source cases: control word and expected count
  logic [31:0] ctl [5] = '{32'h8, 32'hD, 32'h9, 32'hA, 32'hB};
  logic [31:0] cnt [5] = '{32'h0, 32'h4, 32'h3, 32'h2, 32'h1};

  rtc_modulo_counter i_rtc_modulo_counter (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .clk_pins(clk_pins),
    .power_mode(power_mode), .timer1_ccr1_out_b(timer1_ccr1_out_b),
    .capture_input_1b(capture_input_1b), .adc_start(adc_start), .cpu_wake(cpu_wake), .irq(irq));
  rtc_far_side i_rtc_far_side (.ref_clk(ref_clk), .reset_n(reset_n),
    .capture_input_1b(capture_input_1b), .adc_start(adc_start), .clk_pins(clk_pins),
    .timer1_ccr1_out_b(timer1_ccr1_out_b), .capture_count_q(capture_count),
    .start_count_q(start_count));

  // ----------------------------------------
  // Clock, wake counter and hang guard
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_count_q <= 16'h0000;
    end else begin
      wake_count_q <= wake_count_q + 16'(cpu_wake);
    end
  end
  // Whole run needs about 800 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Register port tasks and comparison
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 got = rd_data;
    check(what, exp, got);
  endtask
  // Lets the tick pipeline and event pulses land
  task automatic settle();
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    power_mode = rtc_pkg::ACTIVE_MODE;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 7; i++) rd("reset value", ofs[i], rst[i]);
    // Each pin gets a distinct edge count, so a wrong pick shows
    for (int s = 0; s < 5; s++) begin
      wr(rtc_pkg::OFS_CTRL, ctl[s]);
      for (int p = 0; p < 4; p++) i_rtc_far_side.edges(p, p + 1);
      settle();
      rd("source count", rtc_pkg::OFS_COUNT, cnt[s]);
    end
    // Wrap at modulo 2 in every power mode
    wr(rtc_pkg::OFS_MOD, 32'h2);
    wr(rtc_pkg::OFS_MASK, 32'h1);
    wr(rtc_pkg::OFS_ADC, 32'h1);
    wr(rtc_pkg::OFS_CTRL, 32'hA);
    for (int m = 0; m < 4; m++) begin
      power_mode <= rtc_pkg::power_mode_type'(m);
      c0 = capture_count;
      s0 = start_count;
      w0 = wake_count_q;
      i_rtc_far_side.edges(1, 3);
      settle();
      check("capture", 32'h1, {16'h0, capture_count - c0});
      check("adc start", 32'h1, {16'h0, start_count - s0});
      check("wake", {31'h0, m != 0}, {16'h0, wake_count_q - w0});
      check("irq", 32'h1, {31'h0, irq});
      rd("wrapped count", rtc_pkg::OFS_COUNT, 32'h0);
      rd("status", rtc_pkg::OFS_STATUS, 32'h1);
      repeat (3) @(posedge ref_clk);
      check("irq cleared", 32'h0, {31'h0, irq});
    end
    // Masked flag stays sticky; an overflow must not start the soft source
    wr(rtc_pkg::OFS_MASK, 32'h0);
    wr(rtc_pkg::OFS_ADC, 32'h0);
    s0 = start_count;
    i_rtc_far_side.edges(1, 3);
    settle();
    check("no start", 32'h0, {16'h0, start_count - s0});
    check("irq masked", 32'h0, {31'h0, irq});
    rd("masked status", rtc_pkg::OFS_STATUS, 32'h1);
    // Every start source: soft bit and timer edge offered each time
    for (int t = 0; t < 4; t++) begin
      s0 = start_count;
      wr(rtc_pkg::OFS_ADC, 32'(t) | 32'h4);
      i_rtc_far_side.timer_pulse();
      settle();
      check("start source", {31'h0, t == 0 || t == 2}, {16'h0, start_count - s0});
    end
    tally_and_finish();
  end
endmodule  // rtc_modulo_counter_tb_top
